// ===== rtl/rof_pkg.sv
/*
  rof_pkg: shared constants, register map and carrier types of the
  reading output formatter.
  assumes: nothing; every user writes rof_pkg::name.
*/
package rof_pkg;

  // ==========================================================
  // register map (word index = byte offset / 4)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RDG_LO = 8'h08;
  localparam logic [7:0] REG_RDG_HI = 8'h0c;
  localparam logic [7:0] REG_RDG_CMD = 8'h10;
  localparam logic [7:0] REG_TXT_CHAR = 8'h14;
  localparam logic [7:0] REG_TXT_CMD = 8'h18;
  localparam logic [7:0] REG_TXT_BASE = 8'h40;

  // ==========================================================
  // control field positions
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_SWAP_BIT = 2;
  localparam int CTRL_TEXT_BIT = 3;
  localparam int CTRL_DISP_BIT = 4;
  localparam int CTRL_FUNC_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0010;

  // command word bits
  localparam int CMD_START_BIT = 0;
  localparam int CMD_LAST_BIT = 1;
  localparam int TCMD_BEGIN_BIT = 0;
  localparam int TCMD_END_BIT = 1;
  localparam int TCMD_LOCAL_BIT = 2;
  localparam int TCMD_BLOCK_BIT = 3;

  // ==========================================================
  // framing constants
  localparam logic [7:0] HDR_BYTE0 = 8'h23;
  localparam logic [7:0] HDR_BYTE1 = 8'h30;
  localparam logic [7:0] TERM_BYTE = 8'h0a;
  localparam logic [7:0] SPACE_CHAR = 8'h20;
  localparam logic [7:0] PLUS_CHAR = 8'h2b;
  localparam logic [7:0] MINUS_CHAR = 8'h2d;
  localparam logic [7:0] DIGIT0_CHAR = 8'h30;
  localparam logic [7:0] POINT_CHAR = 8'h2e;
  localparam logic [7:0] EXP_CHAR = 8'h45;
  localparam int TEXT_LEN = 32;
  localparam int HDR_LEN = 2;
  localparam int TERM_LEN = 1;
  localparam int SREAL_LEN = 4;
  localparam int DOUBLE_LEN = 8;
  localparam int ASCII_LEN = 16;
  localparam int SREAL_EXP_W = 8;
  localparam int SREAL_FRAC_W = 23;
  localparam int DOUBLE_EXP_W = 11;
  localparam int DOUBLE_FRAC_W = 52;

  typedef enum logic [1:0] {
    FMT_ASCII,
    FMT_SINGLE,
    FMT_DOUBLE
  } rof_fmt_t;

  // reading as offered by the measurement side
  typedef struct packed {
    logic [63:0] dbl;     // double precision value
    logic [31:0] sgl;     // single precision value
    logic [63:0] ascii_bcd; // 16 bcd nibbles, mantissa digits on top, two exponent digits in the low byte
  } rof_rdg_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rof_byte_t;

endpackage

// ===== rtl/rof_text_store.sv
/*
  rof_text_store: 32-character display message buffer.
  assumes: characters arrive one per strobe between begin and end.
*/
`timescale 1ns/100ps
module rof_text_store #(
  parameter int LEN = rof_pkg::TEXT_LEN
) (
  input wire logic mclk_in, // clock
  input wire logic nrst_in, // async reset, low
  input wire logic begin_in, // start a new message
  input wire logic char_in, // character strobe
  input wire logic [7:0] char_data_in, // character code
  input wire logic end_in, // message complete
  input wire logic [4:0] rd_idx_in, // presentation index
  output logic [7:0] rd_char_out, // character at index
  input wire logic [4:0] reg_idx_in, // register readback index
  output logic [7:0] reg_char_out, // character at readback index
  output logic too_long_out // last message overflowed
);

  logic [7:0] buf_mem [LEN];
  logic [7:0] stage_mem [LEN];
  logic [6:0] wr_cnt;
  logic over;

  // ==========================================================
  // staging buffer; committed only if it fits, so a long one never shows
  generate
    for (genvar i = 0; i < LEN; i++) begin : g_chr
      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          buf_mem[i] <= rof_pkg::SPACE_CHAR; // [R03]
          stage_mem[i] <= rof_pkg::SPACE_CHAR;
        end else if (begin_in) begin
          stage_mem[i] <= rof_pkg::SPACE_CHAR; // [R01]
        end else if (char_in && !over && wr_cnt == 7'(i)) begin
          stage_mem[i] <= char_data_in; // [R21]
        end else if (end_in && !over) begin
          buf_mem[i] <= stage_mem[i]; // [R01]
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_cnt <= 7'h00;
      over <= 1'b0;
      too_long_out <= 1'b0;
    end else if (begin_in) begin
      wr_cnt <= 7'h00;
      over <= 1'b0;
    end else if (char_in) begin
      if (wr_cnt == 7'(LEN)) begin
        over <= 1'b1; // [R02]
      end else begin
        wr_cnt <= wr_cnt + 7'h01;
      end
    end else if (end_in) begin
      too_long_out <= over; // [R02]
    end
  end

  assign rd_char_out = buf_mem[rd_idx_in];
  assign reg_char_out = buf_mem[reg_idx_in];

endmodule

// ===== rtl/rof_ascii_fmt.sv
/*
  rof_ascii_fmt: builds the ASCII characters of one reading.
  assumes: bcd mantissa digits and a signed decimal exponent given.
*/
`timescale 1ns/100ps
module rof_ascii_fmt (
  input wire logic neg_in, // mantissa negative
  input wire logic [63:0] bcd_in, // 16 digits, top nibble first
  input wire logic exp_neg_in, // exponent negative
  input wire logic [7:0] exp_bcd_in, // two exponent digits
  input wire logic [3:0] idx_in, // character index 0..15
  output logic [7:0] char_out // character code
);

  // layout: s d . d d d d d d d d space E s d d  [R09]
  // chars 3..10 take bcd digits 14 down to 7, right after the leading one
  logic [3:0] dig;
  assign dig = (idx_in == 4'd1) ? bcd_in[63:60] :
               (idx_in >= 4'd3 && idx_in <= 4'd10) ? bcd_in[6'(5'd17 - {1'b0, idx_in}) * 4 +: 4] :
               (idx_in == 4'd14) ? exp_bcd_in[7:4] : exp_bcd_in[3:0];

  always_comb begin
    case (idx_in)
      4'd0: char_out = neg_in ? rof_pkg::MINUS_CHAR : rof_pkg::PLUS_CHAR;
      4'd2: char_out = rof_pkg::POINT_CHAR;
      4'd11: char_out = rof_pkg::SPACE_CHAR;
      4'd12: char_out = rof_pkg::EXP_CHAR;
      4'd13: char_out = exp_neg_in ? rof_pkg::MINUS_CHAR : rof_pkg::PLUS_CHAR;
      default: char_out = rof_pkg::DIGIT0_CHAR | {4'h0, dig};
    endcase
  end

endmodule

// ===== rtl/rof_formatter.sv
/*
  rof_formatter: top of the reading output formatter. frames readings as
  ascii or binary byte strings and holds the display message state.
  assumes: plain register port; byte sink drives byte_ready_in.
*/
// Local design decisions: the plain strobed port and the placing of the registers.
//
// Functional notes
// R01: message is 32 chars, space padded
// R02: overlong message is never displayed
// R03: power-up message is 32 spaces
// R04: block text runs to line end
// R05: text mode shows message, off restores display
// R06: leaving remote cancels message and mode
// R07: display disabled blanks, controls except local
// R08: ascii, single or double reading encodings
// R09: ascii: signed mantissa then signed exponent
// R10: binary string starts with hash zero header
// R11: binary string ends with terminator byte
// R12: single: four bytes, 1/8/23 layout
// R13: double: eight bytes, 1/11/52 layout
// R14: selectable normal or swapped byte order
// R15: header never reordered, always first
// R16: ascii ignores swapped order
// R17: commands accepted only as ascii
// R18: length is header plus readings plus one
// R19: host reads whole string before release
// R20: function select picks reading source
// R21: sequential 32-entry buffer, top then bottom
`timescale 1ns/100ps
module rof_formatter #(
  parameter int NFUNC = 4
) (
  input wire logic mclk_in, // clock 100 MHz
  input wire logic nrst_in, // async reset, low
  input wire logic [7:0] addr_in, // register byte address
  input wire logic [31:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [31:0] rdata_out, // read data, cycle after rd
  input wire logic [NFUNC-1:0] rdg_valid_in, // reading ready per function
  input wire rof_pkg::rof_rdg_t rdg_in [NFUNC], // readings per function
  input wire logic local_key_in, // front local key pulse
  input wire logic [7:0] panel_keys_in, // front panel keys
  input wire logic byte_ready_in, // sink takes byte
  output logic byte_valid_out, // byte offered
  output rof_pkg::rof_byte_t byte_out, // byte and last flag
  output logic [7:0] panel_keys_out, // keys passed to ui
  output logic [7:0] disp_char_out, // display character
  input wire logic [4:0] disp_idx_in, // display character index
  output logic disp_text_out, // display shows message
  output logic disp_blank_out // display blanked
);

  // ==========================================================
  // control registers
  logic [31:0] ctrl;
  logic [1:0] fmt_sel;
  logic byte_order_select;
  logic text_mode;
  logic disp_en;
  logic [1:0] func_sel;
  logic double_float_encoding;
  assign fmt_sel = ctrl[rof_pkg::CTRL_FMT_LSB +: 2];
  assign byte_order_select = ctrl[rof_pkg::CTRL_SWAP_BIT];
  assign text_mode = ctrl[rof_pkg::CTRL_TEXT_BIT];
  assign disp_en = ctrl[rof_pkg::CTRL_DISP_BIT];
  assign func_sel = ctrl[rof_pkg::CTRL_FUNC_LSB +: 2];
  assign double_float_encoding = (fmt_sel == 2'(rof_pkg::FMT_DOUBLE));

  wire ctrl_wr = wr_in && addr_in == rof_pkg::REG_CTRL;
  wire rdg_cmd_wr = wr_in && addr_in == rof_pkg::REG_RDG_CMD;
  wire txt_cmd_wr = wr_in && addr_in == rof_pkg::REG_TXT_CMD;
  wire txt_chr_wr = wr_in && addr_in == rof_pkg::REG_TXT_CHAR;
  wire go_local = local_key_in || (txt_cmd_wr && wdata_in[rof_pkg::TCMD_LOCAL_BIT]);
  wire blk_mode_wr = txt_cmd_wr && wdata_in[rof_pkg::TCMD_BLOCK_BIT];

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= rof_pkg::CTRL_RESET;
    end else if (go_local) begin
      // leaving remote drops text mode and wakes the display  [R06] [R07]
      ctrl[rof_pkg::CTRL_TEXT_BIT] <= 1'b0;
      ctrl[rof_pkg::CTRL_DISP_BIT] <= 1'b1;
    end else if (ctrl_wr) begin
      ctrl <= wdata_in & 32'h0000_031f;
    end
  end

  // ==========================================================
  // text message input; block mode eats line until terminator  [R04]
  logic blk_active;
  logic txt_begin, txt_end;
  wire txt_line_end = txt_chr_wr && blk_active && wdata_in[7:0] == rof_pkg::TERM_BYTE;
  assign txt_begin = txt_cmd_wr && wdata_in[rof_pkg::TCMD_BEGIN_BIT];
  assign txt_end = (txt_cmd_wr && wdata_in[rof_pkg::TCMD_END_BIT] && !blk_active)
                   || txt_line_end;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      blk_active <= 1'b0;
    end else if (txt_line_end) begin
      blk_active <= 1'b0;
    end else if (blk_mode_wr) begin
      blk_active <= 1'b1; // [R04]
    end
  end

  logic [7:0] txt_char;
  logic [7:0] txt_reg_char;
  logic too_long;
  wire [7:0] txt_off = addr_in - rof_pkg::REG_TXT_BASE;
  wire txt_hit = addr_in >= rof_pkg::REG_TXT_BASE && txt_off < 8'h80;
  wire [4:0] txt_rd_idx = txt_off[6:2];
  rof_text_store u_text (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .begin_in(txt_begin),
    .char_in(txt_chr_wr && !txt_line_end),
    .char_data_in(wdata_in[7:0]),
    .end_in(txt_end),
    .rd_idx_in(disp_idx_in),
    .rd_char_out(txt_char),
    .reg_idx_in(txt_rd_idx),
    .reg_char_out(txt_reg_char),
    .too_long_out(too_long)
  );

  // ==========================================================
  // display outputs
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      disp_char_out <= rof_pkg::SPACE_CHAR;
      disp_text_out <= 1'b0;
      disp_blank_out <= 1'b0;
      panel_keys_out <= 8'h00;
    end else begin
      disp_blank_out <= !disp_en; // [R07]
      disp_text_out <= disp_en && text_mode; // [R05]
      disp_char_out <= txt_char; // [R05] [R21]
      panel_keys_out <= disp_en ? panel_keys_in : 8'h00; // [R07]
    end
  end

  // ==========================================================
  // reading framer
  typedef enum {
    ST_IDLE,
    ST_HDR0,
    ST_HDR1,
    ST_DATA,
    ST_WAIT,
    ST_TERM
  } rof_state_t;
  rof_state_t state, next_state;

  rof_pkg::rof_rdg_t cur;
  logic [63:0] hold_dbl;
  logic [3:0] idx;
  logic last_rdg;
  logic pend;
  logic [1:0] fmt_lat;
  logic swap_lat;
  logic [7:0] exp_bcd;
  logic exp_neg;

  // five bits, so the full 16-character ascii reading fits  [R09]
  wire [4:0] nbytes = (fmt_lat == 2'(rof_pkg::FMT_DOUBLE)) ? 5'(rof_pkg::DOUBLE_LEN) :
                      (fmt_lat == 2'(rof_pkg::FMT_SINGLE)) ? 5'(rof_pkg::SREAL_LEN) :
                      5'(rof_pkg::ASCII_LEN);
  wire binary = fmt_lat != 2'(rof_pkg::FMT_ASCII);
  // ascii always normal order  [R16]
  wire [3:0] bidx = (swap_lat && binary) ? 4'(nbytes - 5'd1 - {1'b0, idx}) : idx; // [R14]
  wire [63:0] bin_word = (fmt_lat == 2'(rof_pkg::FMT_DOUBLE)) ? hold_dbl :
                         {hold_dbl[31:0], 32'h0}; // [R12] [R13]
  wire [7:0] bin_byte = bin_word[6'(4'd7 - bidx) * 8 +: 8];
  logic [7:0] asc_byte;

  rof_ascii_fmt u_ascii (
    .neg_in(cur.sgl[31]),
    .bcd_in(cur.ascii_bcd),
    .exp_neg_in(exp_neg),
    .exp_bcd_in(exp_bcd),
    .idx_in(idx),
    .char_out(asc_byte)
  );

  wire start = rdg_cmd_wr && wdata_in[rof_pkg::CMD_START_BIT];
  wire fire = byte_valid_out && byte_ready_in;
  wire data_last = {1'b0, idx} == nbytes - 5'd1;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = pend ? (binary ? ST_HDR0 : ST_DATA) : ST_IDLE;
      ST_HDR0: next_state = fire ? ST_HDR1 : ST_HDR0; // [R10] [R15]
      ST_HDR1: next_state = fire ? ST_DATA : ST_HDR1;
      // ascii has no terminator byte, so its last reading returns to idle
      ST_DATA: next_state = (fire && data_last) ?
                            (last_rdg ? (binary ? ST_TERM : ST_IDLE) : ST_WAIT) : ST_DATA;
      ST_WAIT: next_state = pend ? ST_DATA : ST_WAIT;
      ST_TERM: next_state = fire ? ST_IDLE : ST_TERM; // [R11] [R18]
      default: next_state = ST_IDLE;
    endcase
  end

  // exponent field taken from the sign-aware measurement side as bcd
  assign exp_bcd = cur.ascii_bcd[7:0];
  assign exp_neg = cur.dbl[62] == 1'b0;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      pend <= 1'b0;
      last_rdg <= 1'b0;
      idx <= 4'h0;
      fmt_lat <= 2'h0;
      swap_lat <= 1'b0;
      cur <= '0;
      hold_dbl <= 64'h0;
    end else begin
      state <= next_state;
      if (start && !pend && (state == ST_IDLE || state == ST_WAIT)) begin
        pend <= 1'b1;
        last_rdg <= wdata_in[rof_pkg::CMD_LAST_BIT];
        cur <= rdg_in[func_sel]; // [R20]
        hold_dbl <= double_float_encoding ? rdg_in[func_sel].dbl :
                    {32'h0, rdg_in[func_sel].sgl}; // [R08]
        if (state == ST_IDLE) begin
          fmt_lat <= fmt_sel; // [R08]
          swap_lat <= byte_order_select; // [R14]
        end
      end else if (next_state == ST_DATA && state != ST_DATA) begin
        pend <= 1'b0;
        idx <= 4'h0;
      end
      if (state == ST_DATA && fire) begin
        idx <= data_last ? 4'h0 : idx + 4'h1;
      end
    end
  end

  always_comb begin
    byte_valid_out = state == ST_HDR0 || state == ST_HDR1 ||
                     state == ST_DATA || (state == ST_TERM && binary);
    byte_out.last = state == ST_TERM || (state == ST_DATA && data_last && last_rdg && !binary);
    case (state)
      ST_HDR0: byte_out.data = rof_pkg::HDR_BYTE0; // [R10]
      ST_HDR1: byte_out.data = rof_pkg::HDR_BYTE1;
      ST_DATA: byte_out.data = binary ? bin_byte : asc_byte; // [R09]
      ST_TERM: byte_out.data = rof_pkg::TERM_BYTE; // [R11]
      default: byte_out.data = 8'h00;
    endcase
  end

  // ==========================================================
  // register read; status shows framer and message state
  // commands arrive only as ascii characters or command words  [R17]
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0;
    if (addr_in == rof_pkg::REG_CTRL) begin
      next_rdata = ctrl;
    end else if (addr_in == rof_pkg::REG_STATUS) begin
      next_rdata = {26'h0, blk_active, too_long, pend, 3'(state)};
    end else if (txt_hit) begin
      next_rdata = {24'h0, txt_reg_char};
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= rd_in ? next_rdata : 32'h0;
    end
  end

endmodule

// ===== tb/rof_formatter_checker.sv
/*
  rof_formatter_checker: port-level properties of the reading output formatter.
  assumes: bound to rof_formatter; one clock, async active-low reset.
*/
`timescale 1ns/100ps
module rof_formatter_checker #(
  parameter int NFUNC = 4
) (
  input wire logic mclk_in, // clock
  input wire logic nrst_in, // async reset, low
  input wire logic [7:0] addr_in, // register address
  input wire logic [31:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic local_key_in, // local key pulse
  input wire logic byte_ready_in, // sink takes byte
  input wire logic byte_valid_out, // byte offered
  input wire rof_pkg::rof_byte_t byte_out, // byte and last flag
  input wire logic [7:0] panel_keys_out, // gated keys
  input wire logic disp_text_out, // message shown
  input wire logic disp_blank_out // display blanked
);
  // ==========================================================
  // frame tracking
  logic hs;
  logic ctrl_wr;
  logic in_frame;
  logic [1:0] fmt_q;
  int cnt;
  assign hs = byte_valid_out && byte_ready_in;
  assign ctrl_wr = wr_in && addr_in == rof_pkg::REG_CTRL;
  // format is only followed between frames, as the design latches it at start
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fmt_q <= 2'h0;
      in_frame <= 1'b0;
      cnt <= 0;
    end else begin
      if (ctrl_wr && !in_frame) fmt_q <= wdata_in[1:0];
      if (hs) in_frame <= !byte_out.last;
      if (hs) cnt <= byte_out.last ? 0 : cnt + 1;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_open;
    byte_valid_out && !in_frame;
  endsequence
  sequence s_close;
    hs && byte_out.last;
  endsequence

  AST_HOLD: assert property (byte_valid_out && !byte_ready_in |=> byte_valid_out && $stable(byte_out))
    else $error("offered byte changed before acceptance");
  AST_HDR0: assert property (s_open ##0 fmt_q != 2'h0 |-> byte_out.data == rof_pkg::HDR_BYTE0)
    else $error("binary string does not open with hash");
  AST_HDR1: assert property (s_open ##0 (fmt_q != 2'h0 && byte_ready_in) |=>
    byte_valid_out && byte_out.data == rof_pkg::HDR_BYTE1) else $error("second header byte wrong");
  AST_TERM: assert property (s_close ##0 fmt_q != 2'h0 |-> byte_out.data == rof_pkg::TERM_BYTE)
    else $error("binary string not ended by terminator");
  AST_LEN_S: assert property (s_close ##0 fmt_q == 2'h1 |-> cnt % 4 == 2)
    else $error("single precision string length wrong");
  AST_LEN_D: assert property (s_close ##0 fmt_q == 2'h2 |-> cnt % 8 == 2)
    else $error("double precision string length wrong");
  AST_ASCII: assert property (s_open ##0 fmt_q == 2'h0 |->
    byte_out.data inside {rof_pkg::PLUS_CHAR, rof_pkg::MINUS_CHAR}) else $error("ascii sign missing");
  AST_LEN_A: assert property (s_close ##0 fmt_q == 2'h0 |-> cnt % 16 == 15)
    else $error("ascii reading length wrong");
  AST_BLANK: assert property (ctrl_wr && !wdata_in[rof_pkg::CTRL_DISP_BIT] && !local_key_in |->
    ##[1:2] disp_blank_out)
    else $error("display not blanked");
  AST_KEYS: assert property (disp_blank_out && $past(disp_blank_out) |-> panel_keys_out == 8'h00)
    else $error("panel keys pass while display disabled");
  AST_LOCAL: assert property (local_key_in |-> ##[1:2] (!disp_text_out && !disp_blank_out))
    else $error("local key left message or blank active");
  AST_TEXT: assert property (ctrl_wr && wdata_in[rof_pkg::CTRL_TEXT_BIT] && !local_key_in &&
    wdata_in[rof_pkg::CTRL_DISP_BIT] |-> ##[1:2] disp_text_out) else $error("text mode not shown");
endmodule

// ===== tb/rof_byte_sink.sv
/*
  rof_byte_sink: controlling computer reading the formatted byte string.
  assumes: one byte per handshake; slow mode stalls every other cycle.
*/
`timescale 1ns/100ps
module rof_byte_sink (
  input wire logic mclk_in, // clock
  input wire logic nrst_in, // async reset, low
  input wire logic slow_in, // stall every other cycle
  input wire logic byte_valid_in, // byte offered
  input wire rof_pkg::rof_byte_t byte_in, // byte and last flag
  output logic byte_ready_out // byte taken
);
  rof_pkg::rof_byte_t got [$];
  // whole string incl. terminator taken before the bench releases it
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      byte_ready_out <= 1'b0;
    end else begin
      if (byte_valid_in && byte_ready_out) got.push_back(byte_in);
      byte_ready_out <= slow_in ? !byte_ready_out : 1'b1;
    end
  end
endmodule

// ===== tb/rof_formatter_tb.sv
/*
  rof_formatter_tb: self-checking bench of the reading output formatter.
  assumes: rof_byte_sink and rof_formatter_checker compiled before it.
*/
`timescale 1ns/100ps
module rof_formatter_tb;
  // ==========================================================
  // signals
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic local_key_in = 1'b0;
  logic [7:0] panel_keys_in = 8'h00;
  logic [4:0] disp_idx_in = 5'h00;
  logic slow = 1'b0;
  logic byte_ready_in, byte_valid_out, disp_text_out, disp_blank_out;
  logic [31:0] rdata_out;
  logic [31:0] d;
  logic [7:0] panel_keys_out, disp_char_out;
  rof_pkg::rof_byte_t byte_out;
  rof_pkg::rof_rdg_t rdg [4];
  rof_pkg::rof_byte_t held [$];
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #5 mclk_in = ~mclk_in;

  rof_formatter #(.NFUNC(4)) u_dut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rdg_valid_in(4'hf),
    .rdg_in(rdg), .local_key_in(local_key_in), .panel_keys_in(panel_keys_in),
    .byte_ready_in(byte_ready_in), .byte_valid_out(byte_valid_out), .byte_out(byte_out),
    .panel_keys_out(panel_keys_out), .disp_char_out(disp_char_out),
    .disp_idx_in(disp_idx_in), .disp_text_out(disp_text_out), .disp_blank_out(disp_blank_out));
  rof_byte_sink u_sink (.mclk_in(mclk_in), .nrst_in(nrst_in), .slow_in(slow),
    .byte_valid_in(byte_valid_out), .byte_in(byte_out), .byte_ready_out(byte_ready_in));

  // ==========================================================
  // shared tasks
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic txt(input int i, input logic [7:0] e);
    rd(rof_pkg::REG_TXT_BASE + 8'(4 * i), d);
    check(32'(d[7:0]), 32'(e));
  endtask
  task automatic chars(input string s);
    foreach (s[k]) wr(rof_pkg::REG_TXT_CHAR, 32'(s[k]));
  endtask
  task automatic pulse_local();
    @(posedge mclk_in);
    local_key_in <= 1'b1;
    @(posedge mclk_in);
    local_key_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
  endtask
  // one single-reading string; bit0 start, bit1 last reading
  task automatic run(input logic [31:0] ctrl);
    int k;
    wr(rof_pkg::REG_CTRL, ctrl);
    u_sink.got.delete();
    wr(rof_pkg::REG_RDG_CMD, 32'h3);
    for (k = 0; k < 400 && !(u_sink.got.size() > 0 && u_sink.got[$].last); k++) @(posedge mclk_in);
    repeat (4) @(posedge mclk_in);
    held = u_sink.got;
  endtask
  task automatic frame(input logic [31:0] ctrl, input logic [63:0] v, input int nb);
    logic [7:0] e [$];
    int k;
    e = '{rof_pkg::HDR_BYTE0, rof_pkg::HDR_BYTE1};
    for (k = 0; k < nb; k++) e.push_back(ctrl[2] ? v[8*k +: 8] : v[8*(nb-1-k) +: 8]);
    e.push_back(rof_pkg::TERM_BYTE);
    run(ctrl);
    check(32'(held.size()), 32'(e.size()));
    foreach (e[i]) check(32'(held[i]), {23'h0, e[i], 1'(i == e.size() - 1)});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(rof_pkg::REG_CTRL, d);
    check(d, rof_pkg::CTRL_RESET);
    check({30'h0, disp_text_out, disp_blank_out}, 32'h0);
    txt(0, rof_pkg::SPACE_CHAR);
    txt(31, rof_pkg::SPACE_CHAR);
  endtask
  // fmt and function share the index: 1 single from function 1, 2 double from 2
  task automatic t_binary();
    int f;
    int sw;
    for (f = 1; f < 3; f++) begin
      for (sw = 0; sw < 2; sw++) begin
        @(posedge mclk_in);
        slow <= 1'(sw);
        frame(32'h10 | 32'(f) | 32'(sw) << 2 | 32'(f) << 8,
          f == 1 ? 64'(rdg[1].sgl) : rdg[2].dbl, 4 * f);
      end
    end
  endtask
  task automatic t_ascii();
    rof_pkg::rof_byte_t a [$];
    run(32'h0000_0310);
    a = held;
    check(32'(a.size()), 32'(rof_pkg::ASCII_LEN));
    check(32'(a[0].data inside {rof_pkg::PLUS_CHAR, rof_pkg::MINUS_CHAR}), 32'h1);
    check({a[1].data, a[2].data, a[6].data, a[12].data}, 32'h312e_3845);
    check(32'(a[$].last), 32'h1);
    run(32'h0000_0314);
    check(32'(held.size()), 32'(a.size()));
    foreach (a[i]) check(32'(held[i]), 32'(a[i]));
  endtask
  task automatic t_text();
    wr(rof_pkg::REG_TXT_CMD, 32'h1);
    chars("AB");
    wr(rof_pkg::REG_TXT_CMD, 32'h2);
    txt(0, 8'h41);
    txt(2, rof_pkg::SPACE_CHAR);
    txt(31, rof_pkg::SPACE_CHAR);
    @(posedge mclk_in);
    disp_idx_in <= 5'h01;
    wr(rof_pkg::REG_CTRL, 32'h18);
    repeat (3) @(posedge mclk_in);
    #1;
    check({30'h0, disp_text_out, disp_blank_out}, 32'h2);
    check(32'(disp_char_out), 32'h42);
    pulse_local();
    check(32'(disp_text_out), 32'h0);
    rd(rof_pkg::REG_CTRL, d);
    check(32'(d[rof_pkg::CTRL_TEXT_BIT]), 32'h0);
    wr(rof_pkg::REG_TXT_CMD, 32'h1);
    repeat (33) wr(rof_pkg::REG_TXT_CHAR, 32'h5a);
    wr(rof_pkg::REG_TXT_CMD, 32'h2);
    rd(rof_pkg::REG_STATUS, d);
    check(32'(d[4]), 32'h1);
    txt(0, 8'h41);
    wr(rof_pkg::REG_TXT_CMD, 32'h9);
    chars("Q;X\n");
    txt(1, 8'h3b);
    txt(2, 8'h58);
  endtask
  task automatic t_disp();
    @(posedge mclk_in);
    panel_keys_in <= 8'h5a;
    wr(rof_pkg::REG_CTRL, 32'h0);
    repeat (3) @(posedge mclk_in);
    #1;
    check({23'h0, disp_blank_out, panel_keys_out}, {23'h0, 1'b1, 8'h00});
    pulse_local();
    check({23'h0, disp_blank_out, panel_keys_out}, {23'h0, 1'b0, 8'h5a});
  endtask

  initial begin
    foreach (rdg[i]) rdg[i] = '{64'h0123_4567_89ab_cdef, 32'h7f00_0001, 64'h1005_8000_0000_0000};
    rdg[1].sgl = 32'hc1a0_0000;
    rdg[2].dbl = 64'hc024_1db2_2d0e_5604;
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_binary();
    t_ascii();
    t_text();
    t_disp();
    close_out();
  end
endmodule

bind rof_formatter rof_formatter_checker #(.NFUNC(NFUNC)) u_chk (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .local_key_in(local_key_in), .byte_ready_in(byte_ready_in),
  .byte_valid_out(byte_valid_out), .byte_out(byte_out), .panel_keys_out(panel_keys_out),
  .disp_text_out(disp_text_out), .disp_blank_out(disp_blank_out));
